// >>> pkg/accel_bank_consts.svh
// Purpose: Constants of the accelerometer register bank
// Assumes: 250 MHz reference clock, serial link on its own clock
// Notes: Functional notes below
// Functional notes
// RULE1: X high register returns result bits 11..4, bit 11 on top.
// RULE2: X low register returns bits 3..0 in its upper nibble.
// RULE3: Y result split over high and low register likewise.
// RULE4: Z result split over high and low register likewise.
// RULE5: Writing key 0xca to reload register reloads correction values.
// RULE6: Rising edge of enable pin also reloads correction values.
// RULE7: Status bit 0 mirrors the free-fall interrupt output.
// RULE8: Host writing status bit 0 as zero clears free-fall interrupt.
// RULE9: Status bit 1 mirrors the motion interrupt output.
// RULE10: Host writing status bit 1 as zero clears motion interrupt.
// RULE11: Operation control resets to 0x42; bits 4 and 3 fixed zero.
// RULE12: Free-fall interrupt only while its enable bit is one.
// RULE13: Self-test bit readable, activates self-test when operation enabled.
// RULE14: Operation bit 6 selects normal operation, else standby.
// RULE15: Clock-hold bit holds serial clock low during conversions.
// RULE16: Host should clear clock-hold whenever it clears enable.
// RULE17: Interrupt config resets to zero; bit 2 fixed zero.
// RULE18: Rate bits select 250 Hz, 1 kHz, 4 kHz or 16 kHz sampling.
// RULE19: Motion non-latching: output follows the motion criterion.
// RULE20: Motion latching: output holds until motion enable pin low.
// RULE21: Free-fall non-latching: output follows the free-fall criterion.
// RULE22: Free-fall latching: output holds until its enable bit cleared.
// RULE23: Free-fall when all axes below threshold for debounce count.
// RULE24: Motion when any axis above threshold for debounce count.
// RULE25: Delay registers count consecutive qualifying samples at chosen rate.
// RULE26: Threshold count equals sixteen conversion counts.
// RULE27: Fixed-zero and don't-care bits read back as zero.
`ifndef ACCEL_BANK_CONSTS_SVH
`define ACCEL_BANK_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_X_HIGH        4'h0
`define OFF_X_LOW         4'h1
`define OFF_Y_HIGH        4'h2
`define OFF_Y_LOW         4'h3
`define OFF_Z_HIGH        4'h4
`define OFF_Z_LOW         4'h5
`define OFF_RELOAD        4'h6
`define OFF_FF_THRESHOLD  4'h8
`define OFF_FF_DEBOUNCE   4'h9
`define OFF_MOT_THRESHOLD 4'ha
`define OFF_MOT_DEBOUNCE  4'hb
`define OFF_INT_CONFIG    4'hc
`define OFF_OP_CONTROL    4'hd
`define OFF_INT_STATUS    4'he
`define REG_COUNT         16

// ----------------------------------------
// Reset values, masks, fields
// ----------------------------------------
`define RST_OP_CONTROL    8'h42
`define RST_INT_CONFIG    8'h00
`define RST_FF_THRESHOLD  8'h0e
`define RST_FF_DEBOUNCE   8'h01
`define RST_MOT_THRESHOLD 8'h55
`define RST_MOT_DEBOUNCE  8'h01
`define MASK_OP_CONTROL   8'he2
`define MASK_INT_CONFIG   8'h1b
`define RELOAD_KEY        8'hca
`define ZERO_G            12'h800
`define BIT_FF_ENABLE     1
`define BIT_SELF_TEST     5
`define BIT_OP_ENABLE     6
`define BIT_CLOCK_HOLD    7
`define BIT_MOT_LATCH     3
`define BIT_FF_LATCH      4
`define BIT_FF_STATUS     0
`define BIT_MOT_STATUS    1
`define BIT_READ_CMD      7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ            250000000
`define RATE_250_HZ       250
`define RATE_1K_HZ        1000
`define RATE_4K_HZ        4000
`define RATE_16K_HZ       16000

`endif

// >>> pkg/accel_bank_pkg.sv
// Purpose: Types of the accelerometer register bank
// Assumes: Nothing
// Notes: Constants live in the consts header
package accel_bank_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [11:0] axis_result_t;
	typedef logic [19:0] tick_count_t;
	typedef enum logic [1:0] {RATE_SLOWEST, RATE_SLOW, RATE_FAST, RATE_FASTEST} debounce_rate_t;
endpackage

// >>> verilog/accel_register_interrupt_bank.sv
// Purpose: Register bank, interrupt detection and serial register port
// Assumes: Mode 0 serial link, chip select low frames a transfer
// Notes: Read values come from a snapshot frozen while selected
`timescale 1ns/1ps
`default_nettype none
`include "accel_bank_consts.svh"

module accel_register_interrupt_bank #(
	parameter int TICKS_250_HZ = `CLK_HZ / `RATE_250_HZ,
	parameter int TICKS_1K_HZ  = `CLK_HZ / `RATE_1K_HZ,
	parameter int TICKS_4K_HZ  = `CLK_HZ / `RATE_4K_HZ,
	parameter int TICKS_16K_HZ = `CLK_HZ / `RATE_16K_HZ
) (
	// Clock and reset
	input  wire logic                         i_ref_clk,
	input  wire logic                         i_rstn,
	// Serial register link
	input  wire logic                         i_sclk,
	input  wire logic                         i_cs_n,
	input  wire logic                         i_mosi,
	output logic                              o_miso,
	output logic                              o_miso_oe_n,
	// Converter side
	input  wire accel_bank_pkg::axis_result_t i_x_result,
	input  wire accel_bank_pkg::axis_result_t i_y_result,
	input  wire accel_bank_pkg::axis_result_t i_z_result,
	input  wire logic                         i_result_valid,
	input  wire logic                         i_conv_busy,
	// Device pins
	input  wire logic                         i_enable_pin,
	input  wire logic                         i_motion_enable_pin,
	output logic                              o_freefall_irq,
	output logic                              o_motion_irq,
	output logic                              o_scl_oe_n,
	// Sensor controls
	output logic                              o_calib_reload,
	output logic                              o_operating,
	output logic                              o_self_test
);

	// ----------------------------------------
	// Link domain: shift in, command decode
	// ----------------------------------------
	logic [2:0]                bit_cnt;
	logic                      cmd_done;
	logic                      cmd_read;
	logic [6:0]                cmd_addr;
	logic [6:0]                shift_in;
	logic [6:0]                wr_addr_hold;
	accel_bank_pkg::reg_byte_t wr_data_hold;
	logic                      wr_tgl;
	accel_bank_pkg::reg_byte_t snap [`REG_COUNT];

	always_ff @(posedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_cnt  <= 3'h0;
			cmd_done <= 1'b0;
			cmd_read <= 1'b0;
			cmd_addr <= 7'h00;
			shift_in <= 7'h00;
		end else begin
			bit_cnt  <= bit_cnt + 3'h1;
			shift_in <= {shift_in[5:0], i_mosi};
			if (bit_cnt == 3'h7 && !cmd_done) begin
				cmd_done <= 1'b1;
				cmd_read <= shift_in[6];
				cmd_addr <= {shift_in[5:0], i_mosi};
			end
		end
	end

	// Write capture survives the frame end
	always_ff @(posedge i_sclk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_tgl       <= 1'b0;
			wr_addr_hold <= 7'h00;
			wr_data_hold <= 8'h00;
		end else if (bit_cnt == 3'h7 && cmd_done && !cmd_read) begin
			wr_tgl       <= ~wr_tgl;
			wr_addr_hold <= cmd_addr;
			wr_data_hold <= {shift_in, i_mosi};
		end
	end

	// ----------------------------------------
	// Link domain: shift out with auto-increment
	// ----------------------------------------
	logic [6:0]                rd_off;
	logic [6:0]                rd_idx;
	accel_bank_pkg::reg_byte_t shift_out;

	assign rd_idx = cmd_addr + rd_off;

	always_ff @(negedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			rd_off    <= 7'h00;
			shift_out <= 8'h00;
		end else if (bit_cnt == 3'h0 && cmd_done && cmd_read) begin
			rd_off    <= rd_off + 7'h1;
			shift_out <= (rd_idx < 7'(`REG_COUNT)) ? snap[rd_idx[3:0]] : 8'h00;
		end else begin
			shift_out <= {shift_out[6:0], 1'b0};
		end
	end

	assign o_miso = shift_out[7];

	// ----------------------------------------
	// Crossings into the reference domain
	// ----------------------------------------
	logic [2:0] wr_sync;
	logic [1:0] cs_sync;
	logic [1:0] en_sync;
	logic [1:0] men_sync;
	logic       en_prev;
	logic       wr_pulse;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_sync  <= 3'h0;
			cs_sync  <= 2'h3;
			en_sync  <= 2'h0;
			men_sync <= 2'h0;
			en_prev  <= 1'b0;
			o_miso_oe_n <= 1'b1;
		end else begin
			wr_sync  <= {wr_sync[1:0], wr_tgl};
			cs_sync  <= {cs_sync[0], i_cs_n};
			en_sync  <= {en_sync[0], i_enable_pin};
			men_sync <= {men_sync[0], i_motion_enable_pin};
			en_prev  <= en_sync[1];
			o_miso_oe_n <= cs_sync[1];
		end
	end

	assign wr_pulse = wr_sync[2] ^ wr_sync[1];

	// ----------------------------------------
	// Control and threshold registers
	// ----------------------------------------
	accel_bank_pkg::reg_byte_t op_control;
	accel_bank_pkg::reg_byte_t int_config;
	accel_bank_pkg::reg_byte_t ff_threshold;
	accel_bank_pkg::reg_byte_t ff_debounce;
	accel_bank_pkg::reg_byte_t mot_threshold;
	accel_bank_pkg::reg_byte_t mot_debounce;
	logic [3:0]                wr_off;
	logic                      wr_ok;

	assign wr_off = wr_addr_hold[3:0];
	assign wr_ok  = wr_pulse && wr_addr_hold[6:4] == 3'h0;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			// RULE11: control reset value
			op_control    <= `RST_OP_CONTROL;
			// RULE17: config reset value
			int_config    <= `RST_INT_CONFIG;
			ff_threshold  <= `RST_FF_THRESHOLD;
			ff_debounce   <= `RST_FF_DEBOUNCE;
			mot_threshold <= `RST_MOT_THRESHOLD;
			mot_debounce  <= `RST_MOT_DEBOUNCE;
		end else if (wr_ok) begin
			unique case (wr_off)
				// RULE27: fixed bits masked
				`OFF_OP_CONTROL:    op_control    <= wr_data_hold & `MASK_OP_CONTROL;
				`OFF_INT_CONFIG:    int_config    <= wr_data_hold & `MASK_INT_CONFIG;
				`OFF_FF_THRESHOLD:  ff_threshold  <= wr_data_hold;
				`OFF_FF_DEBOUNCE:   ff_debounce   <= wr_data_hold;
				`OFF_MOT_THRESHOLD: mot_threshold <= wr_data_hold;
				`OFF_MOT_DEBOUNCE:  mot_debounce  <= wr_data_hold;
				default: ;
			endcase
		end
	end

	logic operating;
	logic ff_enable;
	logic ff_latch;
	logic mot_latch;

	// RULE14: enable selects operation
	assign operating = op_control[`BIT_OP_ENABLE];
	assign ff_enable = op_control[`BIT_FF_ENABLE];
	assign ff_latch  = int_config[`BIT_FF_LATCH];
	assign mot_latch = int_config[`BIT_MOT_LATCH];

	// ----------------------------------------
	// Calibration reload, pin controls
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_calib_reload <= 1'b0;
			o_operating    <= 1'b0;
			o_self_test    <= 1'b0;
			o_scl_oe_n     <= 1'b1;
		end else begin
			// RULE5: key write reloads
			// RULE6: enable pin rise reloads
			o_calib_reload <= (wr_ok && wr_off == `OFF_RELOAD && wr_data_hold == `RELOAD_KEY)
			               || (en_sync[1] && !en_prev);
			o_operating    <= operating;
			// RULE13: self-test when enabled
			o_self_test    <= operating && op_control[`BIT_SELF_TEST];
			// RULE15: hold clock in conversion
			o_scl_oe_n     <= !(op_control[`BIT_CLOCK_HOLD] && i_conv_busy);
		end
	end

	// ----------------------------------------
	// Axis results
	// ----------------------------------------
	accel_bank_pkg::axis_result_t x_result;
	accel_bank_pkg::axis_result_t y_result;
	accel_bank_pkg::axis_result_t z_result;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			x_result <= `ZERO_G;
			y_result <= `ZERO_G;
			z_result <= `ZERO_G;
		end else if (i_result_valid) begin
			x_result <= i_x_result;
			y_result <= i_y_result;
			z_result <= i_z_result;
		end
	end

	// ----------------------------------------
	// Debounce sample tick
	// ----------------------------------------
	accel_bank_pkg::debounce_rate_t rate;
	accel_bank_pkg::tick_count_t    tick_cnt;
	accel_bank_pkg::tick_count_t    tick_limit;
	logic                           tick;

	assign rate = accel_bank_pkg::debounce_rate_t'(int_config[1:0]);

	// RULE18: rate selection
	always_comb begin
		unique case (rate)
			accel_bank_pkg::RATE_SLOWEST: tick_limit = 20'(TICKS_250_HZ - 1);
			accel_bank_pkg::RATE_SLOW:    tick_limit = 20'(TICKS_1K_HZ - 1);
			accel_bank_pkg::RATE_FAST:    tick_limit = 20'(TICKS_4K_HZ - 1);
			accel_bank_pkg::RATE_FASTEST: tick_limit = 20'(TICKS_16K_HZ - 1);
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tick_cnt <= 20'h00000;
			tick     <= 1'b0;
		end else if (!operating || tick_cnt >= tick_limit) begin
			tick_cnt <= 20'h00000;
			tick     <= operating;
		end else begin
			tick_cnt <= tick_cnt + 20'h00001;
			tick     <= 1'b0;
		end
	end

	// ----------------------------------------
	// Per-axis threshold compare
	// ----------------------------------------
	accel_bank_pkg::axis_result_t axis [3];
	logic [2:0]                   below_ff;
	logic [2:0]                   above_mot;

	assign axis[0] = x_result;
	assign axis[1] = y_result;
	assign axis[2] = z_result;

	for (genvar a = 0; a < 3; a++) begin : g_axis
		accel_bank_pkg::axis_result_t dev;
		assign dev = (axis[a] >= `ZERO_G) ? axis[a] - `ZERO_G : `ZERO_G - axis[a];
		// RULE26: threshold counts of sixteen
		assign below_ff[a]  = dev[11:4] < ff_threshold;
		assign above_mot[a] = dev[11:4] > mot_threshold;
	end

	// ----------------------------------------
	// Debounce counters and criteria
	// ----------------------------------------
	accel_bank_pkg::reg_byte_t ff_cnt;
	accel_bank_pkg::reg_byte_t mot_cnt;
	logic                      ff_crit;
	logic                      mot_crit;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ff_cnt  <= 8'h00;
			mot_cnt <= 8'h00;
		end else if (!operating) begin
			ff_cnt  <= 8'h00;
			mot_cnt <= 8'h00;
		end else if (tick) begin
			// RULE23: all axes below
			// RULE25: consecutive samples counted
			if (!(&below_ff)) begin
				ff_cnt <= 8'h00;
			end else if (ff_cnt != 8'hff) begin
				ff_cnt <= ff_cnt + 8'h01;
			end
			// RULE24: any axis above
			if (!(|above_mot)) begin
				mot_cnt <= 8'h00;
			end else if (mot_cnt != 8'hff) begin
				mot_cnt <= mot_cnt + 8'h01;
			end
		end
	end

	assign ff_crit  = operating && (&below_ff) && ff_cnt >= ff_debounce;
	assign mot_crit = operating && (|above_mot) && mot_cnt >= mot_debounce;

	// ----------------------------------------
	// Interrupt outputs
	// ----------------------------------------
	logic host_clr_ff;
	logic host_clr_mot;

	// RULE8: host clears free-fall
	assign host_clr_ff  = wr_ok && wr_off == `OFF_INT_STATUS && !wr_data_hold[`BIT_FF_STATUS];
	// RULE10: host clears motion
	assign host_clr_mot = wr_ok && wr_off == `OFF_INT_STATUS && !wr_data_hold[`BIT_MOT_STATUS];

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_freefall_irq <= 1'b0;
		end else if (!ff_enable) begin
			// RULE12: never without enable
			o_freefall_irq <= 1'b0;
		end else if (!ff_latch) begin
			// RULE21: follows criterion
			o_freefall_irq <= ff_crit;
		end else begin
			// RULE22: held until enable cleared
			o_freefall_irq <= ff_crit || (o_freefall_irq && !host_clr_ff);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_motion_irq <= 1'b0;
		end else if (!men_sync[1]) begin
			// RULE20: pin low releases
			o_motion_irq <= 1'b0;
		end else if (!mot_latch) begin
			// RULE19: follows criterion
			o_motion_irq <= mot_crit;
		end else begin
			o_motion_irq <= mot_crit || (o_motion_irq && !host_clr_mot);
		end
	end

	// ----------------------------------------
	// Read snapshot, frozen while selected
	// ----------------------------------------
	function automatic accel_bank_pkg::reg_byte_t read_value(input logic [3:0] idx);
		accel_bank_pkg::reg_byte_t v;
		v = 8'h00;
		unique case (idx)
			// RULE1: X high byte
			`OFF_X_HIGH:        v = x_result[11:4];
			// RULE2: X low nibble
			`OFF_X_LOW:         v = {x_result[3:0], 4'h0};
			// RULE3: Y split
			`OFF_Y_HIGH:        v = y_result[11:4];
			`OFF_Y_LOW:         v = {y_result[3:0], 4'h0};
			// RULE4: Z split
			`OFF_Z_HIGH:        v = z_result[11:4];
			`OFF_Z_LOW:         v = {z_result[3:0], 4'h0};
			`OFF_FF_THRESHOLD:  v = ff_threshold;
			`OFF_FF_DEBOUNCE:   v = ff_debounce;
			`OFF_MOT_THRESHOLD: v = mot_threshold;
			`OFF_MOT_DEBOUNCE:  v = mot_debounce;
			`OFF_INT_CONFIG:    v = int_config;
			`OFF_OP_CONTROL:    v = op_control;
			// RULE7: free-fall status
			// RULE9: motion status
			`OFF_INT_STATUS:    v = {6'h00, o_motion_irq, o_freefall_irq};
			default:            v = 8'h00;
		endcase
		return v;
	endfunction

	for (genvar r = 0; r < `REG_COUNT; r++) begin : g_snap
		always_ff @(posedge i_ref_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				snap[r] <= 8'h00;
			end else if (cs_sync[1]) begin
				snap[r] <= read_value(4'(r));
			end
		end
	end

endmodule
`default_nettype wire

// >>> sim/accel_bank_monitor.sv
// Purpose: Port-level checks of the register bank
// Assumes: Reference clock domain only
// Notes: Bound to every bank instance
`timescale 1ns/1ps
`default_nettype none
module accel_bank_monitor (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	// Watched ports
	input wire logic i_cs_n,
	input wire logic i_conv_busy,
	input wire logic i_enable_pin,
	input wire logic i_motion_enable_pin,
	input wire logic o_freefall_irq,
	input wire logic o_motion_irq,
	input wire logic o_scl_oe_n,
	input wire logic o_calib_reload,
	input wire logic o_operating,
	input wire logic o_self_test
);
	sequence s_en_rise;
		!i_enable_pin ##1 i_enable_pin;
	endsequence
	sequence s_mot_pin_low;
		!i_motion_enable_pin [*4];
	endsequence
	property p_self_test_op;
		@(posedge i_ref_clk) disable iff (!i_rstn) o_self_test |-> o_operating;
	endproperty
	a_self_test_op: assert property (p_self_test_op) else $error("self test outside operation");
	property p_mot_pin_low;
		@(posedge i_ref_clk) disable iff (!i_rstn) s_mot_pin_low |-> !o_motion_irq;
	endproperty
	a_mot_pin_low: assert property (p_mot_pin_low) else $error("motion irq with pin low");
	property p_reload_pulse;
		@(posedge i_ref_clk) disable iff (!i_rstn) o_calib_reload |=> !o_calib_reload;
	endproperty
	a_reload_pulse: assert property (p_reload_pulse) else $error("reload pulse too long");
	property p_en_rise;
		@(posedge i_ref_clk) disable iff (!i_rstn) s_en_rise |-> ##[1:5] o_calib_reload;
	endproperty
	a_en_rise: assert property (p_en_rise) else $error("no reload on enable rise");
	property p_reload_cause;
		@(posedge i_ref_clk) disable iff (!i_rstn) o_calib_reload |-> !$past(i_cs_n, 4) || i_enable_pin;
	endproperty
	a_reload_cause: assert property (p_reload_cause) else $error("reload without cause");
	property p_scl_hold;
		@(posedge i_ref_clk) disable iff (!i_rstn) !o_scl_oe_n |-> $past(i_conv_busy);
	endproperty
	a_scl_hold: assert property (p_scl_hold) else $error("clock held outside conversion");
	property p_scl_release;
		@(posedge i_ref_clk) disable iff (!i_rstn) $fell(i_conv_busy) |=> o_scl_oe_n;
	endproperty
	a_scl_release: assert property (p_scl_release) else $error("clock not released");
	property p_ff_standby;
		@(posedge i_ref_clk) disable iff (!i_rstn) $rose(o_freefall_irq) |-> o_operating || $past(o_operating);
	endproperty
	a_ff_standby: assert property (p_ff_standby) else $error("free-fall irq in standby");
	property p_mot_standby;
		@(posedge i_ref_clk) disable iff (!i_rstn) $rose(o_motion_irq) |-> o_operating || $past(o_operating);
	endproperty
	a_mot_standby: assert property (p_mot_standby) else $error("motion irq in standby");
endmodule

bind accel_register_interrupt_bank accel_bank_monitor u_accel_bank_monitor (
	.i_ref_clk(i_ref_clk),
	.i_rstn(i_rstn),
	.i_cs_n(i_cs_n),
	.i_conv_busy(i_conv_busy),
	.i_enable_pin(i_enable_pin),
	.i_motion_enable_pin(i_motion_enable_pin),
	.o_freefall_irq(o_freefall_irq),
	.o_motion_irq(o_motion_irq),
	.o_scl_oe_n(o_scl_oe_n),
	.o_calib_reload(o_calib_reload),
	.o_operating(o_operating),
	.o_self_test(o_self_test)
);
`default_nettype wire

// >>> sim/spi_host_model.sv
// Purpose: Host controller on the serial register link
// Assumes: Mode 0, clock idle low and still between frames
// Notes: Two-byte frames, MSB first
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Serial link
	output logic     o_sclk,
	output logic     o_cs_n,
	output logic     o_mosi,
	input wire logic i_miso
);
	localparam int HALF_NS = 24;
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdata, output logic [7:0] rdata);
		logic [15:0] frame;
		frame = {cmd, wdata};
		#1.3;
		o_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			o_mosi = frame[i];
			#(HALF_NS);
			o_sclk = 1'b1;
			if (i < 8)
				rdata[i] = i_miso;
			#(HALF_NS);
			o_sclk = 1'b0;
		end
		#(HALF_NS);
		o_cs_n = 1'b1;
		#200;
	endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Host model drives the serial link
// Notes: Short debounce tick counts
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int T_RATE [4] = '{40, 20, 10, 5};
	logic i_ref_clk, i_rstn, i_conv_busy, i_result_valid, i_enable_pin, i_motion_enable_pin;
	logic miso_hold = 1'b0;
	accel_bank_pkg::axis_result_t i_x_result, i_y_result, i_z_result;
	wire sclk, cs_n, mosi, miso_line;
	wire o_miso, o_miso_oe_n, o_freefall_irq, o_motion_irq, o_scl_oe_n, o_calib_reload, o_operating, o_self_test;
	int failures = 0, n_tests = 0, n_reload = 0, cyc;

	accel_register_interrupt_bank #(
		.TICKS_250_HZ(T_RATE[0]),
		.TICKS_1K_HZ(T_RATE[1]),
		.TICKS_4K_HZ(T_RATE[2]),
		.TICKS_16K_HZ(T_RATE[3])
	) u_accel_register_interrupt_bank (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_sclk(sclk),
		.i_cs_n(cs_n),
		.i_mosi(mosi),
		.o_miso(o_miso),
		.o_miso_oe_n(o_miso_oe_n),
		.i_x_result(i_x_result),
		.i_y_result(i_y_result),
		.i_z_result(i_z_result),
		.i_result_valid(i_result_valid),
		.i_conv_busy(i_conv_busy),
		.i_enable_pin(i_enable_pin),
		.i_motion_enable_pin(i_motion_enable_pin),
		.o_freefall_irq(o_freefall_irq),
		.o_motion_irq(o_motion_irq),
		.o_scl_oe_n(o_scl_oe_n),
		.o_calib_reload(o_calib_reload),
		.o_operating(o_operating),
		.o_self_test(o_self_test)
	);
	spi_host_model u_spi_host_model (
		.o_sclk(sclk),
		.o_cs_n(cs_n),
		.o_mosi(mosi),
		.i_miso(miso_line)
	);

	// Released data line shows the inverse of its last level
	always @(o_miso or o_miso_oe_n) if (!o_miso_oe_n) miso_hold = ~o_miso;
	assign miso_line = o_miso_oe_n ? miso_hold : o_miso;
	always @(posedge i_ref_clk) if (o_calib_reload === 1'b1) n_reload <= n_reload + 1;

	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic flag(input logic seen, input logic exp);
		check({7'h0, seen}, {7'h0, exp});
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		u_spi_host_model.xfer({1'b0, a}, d, r);
		step(8);
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_spi_host_model.xfer({1'b1, a}, 8'h00, d);
		step(8);
		check(d, exp);
	endtask
	task automatic set_axes(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
		i_x_result = x;
		i_y_result = y;
		i_z_result = z;
		i_result_valid = 1'b1;
		step(1);
		i_result_valid = 1'b0;
		step(3);
	endtask
	task automatic calm();
		set_axes(12'habc, 12'h923, 12'h5f7);
	endtask
	task automatic wait_hi(input logic mot);
		cyc = 0;
		while ((mot ? o_motion_irq : o_freefall_irq) !== 1'b1 && cyc < 1000) begin
			step(1);
			cyc++;
		end
		flag(cyc < 1000, 1'b1);
	endtask

	initial begin
		#300000;
		failures++;
		close_out();
	end

	initial begin
		{i_rstn, i_conv_busy, i_result_valid, i_enable_pin} = 4'h0;
		i_motion_enable_pin = 1'b1;
		{i_x_result, i_y_result, i_z_result} = {3{12'h800}};
		repeat (8) @(posedge i_ref_clk);
		#1 i_rstn = 1'b1;
		step(6);
		rdchk(7'h0d, 8'h42);
		rdchk(7'h0c, 8'h00);
		rdchk(7'h07, 8'h00);
		calm();
		rdchk(7'h00, 8'hab);
		rdchk(7'h01, 8'hc0);
		rdchk(7'h02, 8'h92);
		rdchk(7'h03, 8'h30);
		rdchk(7'h04, 8'h5f);
		rdchk(7'h05, 8'h70);
		wr(7'h06, 8'h35);
		check(8'(n_reload), 8'h00);
		wr(7'h06, 8'hca);
		check(8'(n_reload), 8'h01);
		i_enable_pin = 1'b1;
		step(10);
		check(8'(n_reload), 8'h02);
		wr(7'h0d, 8'hff);
		rdchk(7'h0d, 8'he2);
		flag(o_self_test, 1'b1);
		i_conv_busy = 1'b1;
		step(2);
		flag(o_scl_oe_n, 1'b0);
		i_conv_busy = 1'b0;
		step(2);
		wr(7'h0d, 8'h20);
		check({6'h0, o_operating, o_self_test}, 8'h00);
		i_conv_busy = 1'b1;
		step(2);
		flag(o_scl_oe_n, 1'b1);
		i_conv_busy = 1'b0;
		wr(7'h0c, 8'hff);
		rdchk(7'h0c, 8'h1b);
		wr(7'h0d, 8'h42);
		wr(7'h09, 8'h04);
		for (int r = 0; r < 4; r++) begin
			wr(7'h0c, 8'(r));
			set_axes(12'h800, 12'h800, 12'h800);
			wait_hi(1'b0);
			flag(cyc >= 3 * T_RATE[r] - 2 && cyc <= 4 * T_RATE[r] + 2, 1'b1);
			rdchk(7'h0e, 8'h01);
			calm();
			flag(o_freefall_irq, 1'b0);
		end
		wr(7'h09, 8'h01);
		wr(7'h0c, 8'h13);
		set_axes(12'h800, 12'h800, 12'h900);
		step(20);
		flag(o_freefall_irq, 1'b0);
		set_axes(12'h800, 12'h800, 12'h800);
		wait_hi(1'b0);
		flag(o_freefall_irq, 1'b1);
		calm();
		flag(o_freefall_irq, 1'b1);
		wr(7'h0e, 8'h02);
		flag(o_freefall_irq, 1'b0);
		set_axes(12'h800, 12'h800, 12'h800);
		wait_hi(1'b0);
		calm();
		wr(7'h0d, 8'h40);
		wr(7'h0d, 8'h42);
		flag(o_freefall_irq, 1'b0);
		wr(7'h0d, 8'h40);
		set_axes(12'h800, 12'h800, 12'h800);
		step(40);
		flag(o_freefall_irq, 1'b0);
		calm();
		wr(7'h0d, 8'h42);
		wr(7'h0c, 8'h03);
		set_axes(12'h800, 12'h800, 12'hd5f);
		step(20);
		flag(o_motion_irq, 1'b0);
		set_axes(12'h800, 12'h800, 12'hd60);
		wait_hi(1'b1);
		flag(o_motion_irq, 1'b1);
		rdchk(7'h0e, 8'h02);
		calm();
		flag(o_motion_irq, 1'b0);
		wr(7'h0c, 8'h0b);
		set_axes(12'h800, 12'h800, 12'hf00);
		wait_hi(1'b1);
		calm();
		flag(o_motion_irq, 1'b1);
		wr(7'h0e, 8'h01);
		flag(o_motion_irq, 1'b0);
		set_axes(12'h800, 12'h800, 12'hf00);
		wait_hi(1'b1);
		calm();
		i_motion_enable_pin = 1'b0;
		step(6);
		flag(o_motion_irq, 1'b0);
		close_out();
	end
endmodule
`default_nettype wire
